// file: core/cprc_top.sv
`timescale 1ns/1ps
// Behaviour
// - After power-up drive output-enable/reset low for about one millisecond.
// - Brown-out of the supply resets the read state.
// - Output-enable/reset is always active low; polarity is fixed.
// - Chip enable high means standby with the address counter held reset.
// - In standby data floats and chain enable out stays high.
// - In standby the JTAG pins may float or be driven high.
// - Enabled and below terminal count: count per clock, drive data, chain high.
// - Past terminal count: address freezes, data floats, chain low, reduced current.
// - Terminal count is the top address; one beyond wraps to zero.
// - Counters advance on each valid rising configuration clock edge.
// - After the last word the next clock drops chain out and floats data.
// - Counters reset when output-enable/reset goes low or chip enable goes high.
// - Serial mode outputs one bit per clock; parallel mode one byte.
module cprc_top
  import cprc_pkg::*;
#(
  parameter int unsigned ADDR_W      = cprc_pkg::ADDR_W_DEF,
  parameter int unsigned HOLD_CYCLES = cprc_pkg::POR_HOLD_CYCLES
)
(
  // Configuration clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Supply monitor
  input  wire logic                 brown_out_i,
  // Chip enable and output-enable/reset pin (open drain)
  input  wire logic                 chip_en_n_i,
  input  wire logic                 oe_reset_n_i,
  output logic                      oe_reset_n_o,
  output logic                      oe_reset_oe_o,
  // Customer control bits and array write port
  input  wire logic [CTRL_W-1:0]    ctrl_bits_i,
  input  wire logic                 ctrl_wr_i,
  input  wire logic                 array_wr_i,
  input  wire logic [ADDR_W-1:0]    array_addr_i,
  input  wire logic [7:0]           array_data_i,
  // Data and chain outputs
  output logic [7:0]                data_o,
  output logic [7:0]                data_oe_o,
  output logic                      chain_enable_out_n,
  output logic                      low_power_o,
  output logic                      jtag_pins_high_o
);

  logic [7:0]          mem [0:(1<<ADDR_W)-1];
  logic                por_active;
  logic [ADDR_W-1:0]   addr_r;
  logic [ADDR_W-1:0]   addr_nxt;
  logic [BIT_IDX_W-1:0] bit_r;
  logic [BIT_IDX_W-1:0] bit_nxt;
  logic                past_tc_r;
  logic                past_tc_nxt;
  logic [CTRL_W-1:0]   ctrl_r;
  logic [CTRL_W-1:0]   ctrl_nxt;
  cprc_mode_type       mode;
  logic [7:0]          word;
  logic                last_beat;
  logic [7:0]          data_nxt;
  logic [7:0]          data_oe_nxt;
  logic                chain_nxt;
  logic                low_power_nxt;
  logic                oer_oe_nxt;
  logic [7:0]          data_r;
  logic [7:0]          data_oe_r;
  logic                chain_r;
  logic                low_power_r;
  logic                oer_oe_r;

  cprc_por #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_por (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .brown_out_i (brown_out_i),
    .active_o    (por_active)
  );

  // Array contents; the control bits live apart so they change without a rewrite.
  always_ff @(posedge clk_i)
  begin
    if (array_wr_i)
      mem[array_addr_i] <= array_data_i;
  end

  always_comb
  begin
    if (!por_active || brown_out_i)
      mode = CPRC_POR;
    else if (chip_en_n_i)
      mode = CPRC_STANDBY;
    else if (!oe_reset_n_i)
      mode = CPRC_HELD;
    else
      mode = CPRC_READ;
  end

  assign word = mem[addr_r];

  always_comb
  begin
    if (ctrl_r[CTRL_PAR_BIT])
      last_beat = 1'b1;
    else
      last_beat = (bit_r == BIT_IDX_LAST);
  end

  always_comb
  begin
    addr_nxt      = addr_r;
    bit_nxt       = bit_r;
    past_tc_nxt   = past_tc_r;
    ctrl_nxt      = ctrl_r;
    data_nxt      = 8'h00;
    data_oe_nxt   = 8'h00;
    chain_nxt     = 1'b1;
    low_power_nxt = 1'b0;
    oer_oe_nxt    = 1'b0;
    if (ctrl_wr_i)
      ctrl_nxt = ctrl_bits_i;
    case (mode)
      CPRC_POR:
      begin
        oer_oe_nxt  = 1'b1;
        low_power_nxt = chip_en_n_i;
        addr_nxt    = '0;
        bit_nxt     = BIT_IDX_RST;
        past_tc_nxt = 1'b0;
      end
      CPRC_STANDBY:
      begin
        addr_nxt      = '0;
        bit_nxt       = BIT_IDX_RST;
        past_tc_nxt   = 1'b0;
        low_power_nxt = 1'b1;
      end
      CPRC_HELD:
      begin
        addr_nxt    = '0;
        bit_nxt     = BIT_IDX_RST;
        past_tc_nxt = 1'b0;
      end
      default:
      begin
        if (past_tc_r)
        begin
          chain_nxt     = 1'b0;
          low_power_nxt = 1'b1;
        end
        else
        begin
          if (ctrl_r[CTRL_PAR_BIT])
          begin
            data_nxt    = word;
            data_oe_nxt = 8'hFF;
          end
          else
          begin
            data_nxt    = {7'h00, word[BIT_IDX_LAST - bit_r]};
            data_oe_nxt = 8'h01;
          end
          if (last_beat)
          begin
            bit_nxt  = BIT_IDX_RST;
            addr_nxt = addr_r + ADDR_W'(1);
            if (addr_r == {ADDR_W{1'b1}})
              past_tc_nxt = 1'b1;
          end
          else
            bit_nxt = bit_r + BIT_IDX_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_r      <= '0;
      bit_r       <= BIT_IDX_RST;
      past_tc_r   <= 1'b0;
      ctrl_r      <= CTRL_RST;
      data_r      <= 8'h00;
      data_oe_r   <= 8'h00;
      chain_r     <= 1'b1;
      low_power_r <= 1'b0;
      oer_oe_r    <= 1'b1;
    end
    else
    begin
      addr_r      <= addr_nxt;
      bit_r       <= bit_nxt;
      past_tc_r   <= past_tc_nxt;
      ctrl_r      <= ctrl_nxt;
      data_r      <= data_nxt;
      data_oe_r   <= data_oe_nxt;
      chain_r     <= chain_nxt;
      low_power_r <= low_power_nxt;
      oer_oe_r    <= oer_oe_nxt;
    end
  end

  // Data is registered: each beat appears at the edge that moves the counter past it.
  assign data_o             = data_r;
  assign data_oe_o          = data_oe_r;
  assign chain_enable_out_n = chain_r;
  assign low_power_o        = low_power_r;
  assign jtag_pins_high_o   = low_power_r;
  assign oe_reset_n_o       = 1'b0;
  assign oe_reset_oe_o      = oer_oe_r;

endmodule

// file: core/cprc_pkg.sv
package cprc_pkg;

  // Power-on hold of the output-enable/reset pin, in microseconds.
  localparam int unsigned POR_HOLD_US     = 1000;
  localparam int unsigned CLK_MHZ         = 25;
  localparam int unsigned POR_HOLD_CYCLES = POR_HOLD_US * CLK_MHZ;

  // Default array geometry: 2**ADDR_W bytes.
  localparam int unsigned ADDR_W_DEF      = 10;
  localparam int unsigned BIT_IDX_W       = 3;
  localparam logic [2:0]  BIT_IDX_RST     = 3'h0;
  localparam logic [2:0]  BIT_IDX_LAST    = 3'h7;

  // Customer control bit positions.
  localparam int unsigned CTRL_PAR_BIT    = 0;
  localparam int unsigned CTRL_W          = 1;
  localparam logic [0:0]  CTRL_RST        = 1'h0;

  typedef enum logic [1:0] {
    CPRC_POR,
    CPRC_STANDBY,
    CPRC_HELD,
    CPRC_READ
  } cprc_mode_type;

endpackage

// file: core/cprc_por.sv
`timescale 1ns/1ps
// Power-on hold and brown-out reset generator.
module cprc_por
  import cprc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = cprc_pkg::POR_HOLD_CYCLES
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Supply monitor
  input  wire logic brown_out_i,
  // Status
  output logic      active_o
);

  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             active_r;
  logic             active_nxt;

  always_comb
  begin
    cnt_nxt    = cnt_r;
    active_nxt = active_r;
    if (brown_out_i)
    begin
      cnt_nxt    = '0;
      active_nxt = 1'b0;
    end
    else if (!active_r)
    begin
      if (cnt_r == CNT_W'(HOLD_CYCLES - 1))
        active_nxt = 1'b1;
      else
        cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r    <= '0;
      active_r <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      active_r <= active_nxt;
    end
  end

  assign active_o = active_r;

endmodule

// file: dv/cprc_top_sva.sv
`timescale 1ns/1ps
module cprc_top_sva
(
  // Clock, reset and inputs
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       brown_out_i,
  input wire logic       chip_en_n_i,
  input wire logic       oe_reset_n_i,
  // Outputs
  input wire logic       oe_reset_n_o,
  input wire logic       oe_reset_oe_o,
  input wire logic [7:0] data_oe_o,
  input wire logic       chain_enable_out_n,
  input wire logic       low_power_o,
  input wire logic       jtag_pins_high_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_standby_float: assert property (chip_en_n_i |=>
    data_oe_o == 8'h00 && chain_enable_out_n && low_power_o) else $error("standby outputs");
  a_standby_jtag: assert property (chip_en_n_i |=> jtag_pins_high_o)
    else $error("jtag pins not high");
  a_held_float: assert property (!chip_en_n_i && !oe_reset_n_i |=>
    data_oe_o == 8'h00 && chain_enable_out_n) else $error("held outputs");
  a_drive_chain: assert property (data_oe_o != 8'h00 |->
    chain_enable_out_n && !low_power_o) else $error("driving with chain low");
  a_tc_handoff: assert property ($fell(chain_enable_out_n) |->
    data_oe_o == 8'h00 && low_power_o) else $error("handoff outputs");
  a_tc_freeze: assert property (!chain_enable_out_n && !chip_en_n_i && oe_reset_n_i
    && !brown_out_i |=> !chain_enable_out_n) else $error("chain left terminal");
  a_por_hold: assert property ($rose(rst_n_i) |-> oe_reset_oe_o [*8])
    else $error("power-on hold short");
  a_brown_hold: assert property (brown_out_i |=> oe_reset_oe_o [*8])
    else $error("brown-out hold short");
  a_pin_low: assert property (oe_reset_n_o == 1'b0)
    else $error("pin drive value");
  c_handoff: cover property ($fell(chain_enable_out_n));
  c_parallel: cover property (data_oe_o == 8'hFF);
  c_brown: cover property (brown_out_i);
endmodule
bind cprc_top cprc_top_sva cprc_top_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .brown_out_i(brown_out_i), .chip_en_n_i(chip_en_n_i), .oe_reset_n_i(oe_reset_n_i),
  .oe_reset_n_o(oe_reset_n_o), .oe_reset_oe_o(oe_reset_oe_o), .data_oe_o(data_oe_o),
  .chain_enable_out_n(chain_enable_out_n), .low_power_o(low_power_o),
  .jtag_pins_high_o(jtag_pins_high_o));

// file: dv/cprc_cfg_port.sv
`timescale 1ns/1ps
module cprc_cfg_port
(
  // Clock and pins
  input  wire logic       clk_i,
  input  wire logic       init_low_i,
  input  wire logic       pin_val_i,
  input  wire logic       pin_oe_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] data_oe_i,
  // Wire level and captured bits
  output logic            oe_wire_o,
  output logic [7:0]      shift_o
);
  // The pull-up only wins when neither party pulls the shared wire low.
  assign oe_wire_o = (pin_oe_i ? pin_val_i : 1'b1) & ~init_low_i;
  always_ff @(posedge clk_i)
  begin
    if (data_oe_i[0])
      shift_o <= {shift_o[6:0], data_i[0]};
  end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  import cprc_pkg::*;
  localparam int unsigned AW = 2;
  localparam int unsigned HOLD = 20;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, brown_out_i = 1'b0, chip_en_n_i = 1'b1;
  logic       init_low = 1'b0, ctrl_wr_i = 1'b0, array_wr_i = 1'b0, oe_wire;
  logic       ctrl_bits_i = 1'h0, pin_val, pin_oe, chain_n, low_pwr, jtag_hi;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdat = 8'h00, data_o, data_oe_o, shift;
  logic [7:0] img [4] = '{8'hA5, 8'h3C, 8'h0F, 8'h81};
  int         fails = 0, tests_run = 0;
  always #20 clk_i = ~clk_i;
  cprc_top #(.ADDR_W(AW), .HOLD_CYCLES(HOLD)) cprc_top_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .brown_out_i(brown_out_i), .chip_en_n_i(chip_en_n_i),
    .oe_reset_n_i(oe_wire), .oe_reset_n_o(pin_val), .oe_reset_oe_o(pin_oe),
    .ctrl_bits_i(ctrl_bits_i), .ctrl_wr_i(ctrl_wr_i), .array_wr_i(array_wr_i),
    .array_addr_i(addr), .array_data_i(wdat), .data_o(data_o), .data_oe_o(data_oe_o),
    .chain_enable_out_n(chain_n), .low_power_o(low_pwr), .jtag_pins_high_o(jtag_hi));
  cprc_cfg_port cprc_cfg_port_inst (.clk_i(clk_i), .init_low_i(init_low),
    .pin_val_i(pin_val), .pin_oe_i(pin_oe), .data_i(data_o), .data_oe_i(data_oe_o),
    .oe_wire_o(oe_wire), .shift_o(shift));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Caller sets the enables at a falling edge just before; beat 0 shows one edge later.
  task automatic rd(input logic par, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i);
      if (par)
        chk("byte", img[i], data_o);
      else
        chk("bit", {7'h00, img[i/8][7-i%8]}, {7'h00, data_o[0]});
      chk("oe", par ? 8'hFF : 8'h01, data_oe_o);
    end
  endtask
  task automatic flt(input logic ch, input logic lp);
    @(negedge clk_i);
    chk("float", 8'h00, data_oe_o);
    chk("chain", {7'h00, ch}, {7'h00, chain_n});
    chk("power", {7'h00, lp}, {7'h00, low_pwr});
  endtask
  task automatic t_por();
    repeat (HOLD - 1) @(negedge clk_i);
    chk("hold", 8'h01, {7'h00, pin_oe});
    repeat (3) @(negedge clk_i);
    chk("release", 8'h00, {7'h00, pin_oe});
    for (int i = 0; i < 4; i++)
    begin
      array_wr_i = 1'b1;
      addr = 2'(i);
      wdat = img[i];
      @(negedge clk_i);
    end
    array_wr_i = 1'b0;
  endtask
  task automatic t_serial();
    chip_en_n_i = 1'b0;
    rd(1'b0, 32);
    flt(1'b0, 1'b1);
    repeat (3) flt(1'b0, 1'b1);
    chk("captured", img[3], shift);
  endtask
  task automatic t_restart();
    chip_en_n_i = 1'b1;
    flt(1'b1, 1'b1);
    chk("jtag", 8'h01, {7'h00, jtag_hi});
    chip_en_n_i = 1'b0;
    rd(1'b0, 12);
    init_low = 1'b1;
    flt(1'b1, 1'b0);
    init_low = 1'b0;
    rd(1'b0, 8);
  endtask
  task automatic t_parallel();
    chip_en_n_i = 1'b1;
    ctrl_bits_i = 1'h1;
    ctrl_wr_i = 1'b1;
    @(negedge clk_i);
    ctrl_wr_i = 1'b0;
    chip_en_n_i = 1'b0;
    rd(1'b1, 4);
    flt(1'b0, 1'b1);
  endtask
  task automatic t_brown();
    chip_en_n_i = 1'b1;
    @(negedge clk_i);
    chip_en_n_i = 1'b0;
    rd(1'b1, 2);
    brown_out_i = 1'b1;
    @(negedge clk_i);
    brown_out_i = 1'b0;
    chk("brown", 8'h01, {7'h00, pin_oe});
    flt(1'b1, 1'b0);
    for (int i = 0; i < 40 && pin_oe !== 1'b0; i++)
      @(negedge clk_i);
    rd(1'b1, 4);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // The sequence needs about 135 cycles; the limit leaves wide slack.
  initial
  begin
    #100000;
    fails++;
    conclude();
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_por();
    t_serial();
    t_restart();
    t_parallel();
    t_brown();
    conclude();
  end
endmodule
